// [pwm_pkg.sv]
// Package with register offsets, field layouts and reset values of the match PWM unit.
package pwm_pkg;
  localparam int NUM_MATCH = 7;
  localparam int NUM_OUT = 6;
  localparam int CNT_W = 32;
  localparam int CAP_W = 4;
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_COUNT = 6'h04;
  localparam logic [5:0] ADDR_PRESCALE = 6'h08;
  localparam logic [5:0] ADDR_MATCH_CTRL = 6'h0C;
  localparam logic [5:0] ADDR_EDGE_MODE = 6'h10;
  localparam logic [5:0] ADDR_OUT_ENABLE = 6'h14;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h18;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h1C;
  localparam logic [5:0] ADDR_MATCH_BASE = 6'h20;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLR = 1;
  localparam int CTRL_SRC = 2;
  localparam int CTRL_CAP_LO = 3;
  localparam int CTRL_EDGE_LO = 5;
  localparam int MC_IRQ = 0;
  localparam int MC_RESET = 1;
  localparam int MC_STOP = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] MATCH_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {CAP_RISE, CAP_FALL, CAP_BOTH, CAP_NONE} cap_edge_t;
  typedef logic [CNT_W-1:0] count_t;
endpackage

// [pwm_tick_if.sv]
// Interface carrying count tick and match events between the PWM modules.
`timescale 1ns/100ps
interface pwm_tick_if;
  logic tick;
  logic period_start;
  logic [pwm_pkg::NUM_MATCH-1:0] match_hit;
  modport src (output tick, output period_start, output match_hit);
  modport dst (input tick, input period_start, input match_hit);
endinterface

// [pwm_clk_select.sv]
// Count-clock source selector: peripheral clock ticks or capture input edges.
`timescale 1ns/100ps
module pwm_clk_select
  import pwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic use_capture,
  input wire logic [1:0] cap_sel,
  input wire logic [1:0] cap_edge,
  input wire logic [CAP_W-1:0] capture_in,
  input wire logic [31:0] prescale,
  output logic tick
);
  typedef struct packed {
    logic [CAP_W-1:0] cap_prev;
    logic [31:0] pre_cnt;
  } sel_state_t;
  sel_state_t s_q, s_d;
  logic cap_now, cap_old, edge_hit;

  always_comb begin
    s_d = s_q;
    s_d.cap_prev = capture_in;
    cap_now = capture_in[cap_sel];
    cap_old = s_q.cap_prev[cap_sel];
    case (cap_edge_t'(cap_edge))
      CAP_RISE: edge_hit = cap_now & ~cap_old;
      CAP_FALL: edge_hit = ~cap_now & cap_old;
      CAP_BOTH: edge_hit = cap_now ^ cap_old;
      default: edge_hit = 1'b0;
    endcase
    tick = 1'b0;
    if (!run) begin
      s_d.pre_cnt = 32'h0000_0000;
    end else if (use_capture) begin
      tick = edge_hit;
    end else if (s_q.pre_cnt >= prescale) begin
      s_d.pre_cnt = 32'h0000_0000;
      tick = 1'b1;
    end else begin
      s_d.pre_cnt = s_q.pre_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// [pwm_out_stage.sv]
// Output stage forming the six PWM outputs from match events.
`timescale 1ns/100ps
module pwm_out_stage
  import pwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  pwm_tick_if.dst ev,
  input wire logic [NUM_OUT-1:0] double_edge,
  input wire logic [NUM_OUT-1:0] out_enable,
  output logic [NUM_OUT-1:0] pwm_out
);
  typedef struct packed {
    logic [NUM_OUT-1:0] lvl;
  } out_state_t;
  out_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    for (int n = 1; n <= NUM_OUT; n++) begin
      if (double_edge[n-1] && n >= 2) begin
        // Output n is set by match n-1 and cleared by match n.
        if (ev.match_hit[n-1]) begin
          s_d.lvl[n-1] = 1'b1;
        end
        if (ev.match_hit[n]) begin
          s_d.lvl[n-1] = 1'b0;
        end
      end else begin
        if (ev.period_start) begin
          s_d.lvl[n-1] = 1'b1;
        end
        if (ev.match_hit[n]) begin
          s_d.lvl[n-1] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pwm_out = s_q.lvl & out_enable;
endmodule

// [match_based_pwm_unit.sv]
// Top of the match PWM unit: Avalon-MM registers, counter, match logic and interrupt.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
module match_based_pwm_unit
  import pwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [pwm_pkg::CAP_W-1:0] capture_in,
  output logic [pwm_pkg::NUM_OUT-1:0] pwm_out,
  output logic irq
);
  import pwm_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] prescale;
    logic [3*NUM_MATCH-1:0] match_ctrl;
    logic [NUM_OUT-1:0] edge_mode;
    logic [NUM_OUT-1:0] out_en;
    logic [NUM_MATCH-1:0] irq_status;
    logic [NUM_MATCH-1:0] irq_mask;
    logic [NUM_MATCH-1:0][CNT_W-1:0] match;
    count_t count;
    logic [31:0] rdata;
    logic ack;
  } top_state_t;
  top_state_t s_q, s_d;

  pwm_tick_if ev ();
  logic tick;
  logic [NUM_MATCH-1:0] hit;
  logic [NUM_MATCH-1:0] clr_bits;
  logic do_reset, do_stop;
  logic [31:0] wmask;
  logic access;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nv & m);
  endfunction

  pwm_clk_select u_sel (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(s_q.ctrl[CTRL_RUN] & ~s_q.ctrl[CTRL_CLR]),
    .use_capture(s_q.ctrl[CTRL_SRC]),
    .cap_sel(s_q.ctrl[CTRL_CAP_LO +: 2]),
    .cap_edge(s_q.ctrl[CTRL_EDGE_LO +: 2]),
    .capture_in(capture_in),
    .prescale(s_q.prescale),
    .tick(tick)
  );

  always_comb begin
    for (int i = 0; i < NUM_MATCH; i++) begin
      hit[i] = tick && (s_q.count == s_q.match[i]);
    end
  end

  assign ev.tick = tick;
  assign ev.match_hit = hit;
  assign ev.period_start = hit[0];

  pwm_out_stage u_out (
    .clk_sys(clk_sys),
    .rst(rst),
    .ev(ev),
    .double_edge(s_q.edge_mode),
    .out_enable(s_q.out_en),
    .pwm_out(pwm_out)
  );

  always_comb begin
    s_d = s_q;
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    access = (avs_read | avs_write) & ~s_q.ack;
    s_d.ack = access;
    clr_bits = '0;
    do_reset = hit[0];
    do_stop = 1'b0;
    for (int i = 0; i < NUM_MATCH; i++) begin
      if (hit[i] && s_q.match_ctrl[3*i+MC_RESET]) begin
        do_reset = 1'b1;
      end
      if (hit[i] && s_q.match_ctrl[3*i+MC_STOP]) begin
        do_stop = 1'b1;
      end
    end
    // Counter: CLR holds it at zero; on a tick, reset on match 0 or a reset-enabled match, otherwise count up.
    if (s_q.ctrl[CTRL_CLR]) begin
      s_d.count = '0;
    end else if (tick) begin
      if (do_reset) begin
        s_d.count = '0;
      end else begin
        s_d.count = s_q.count + 32'h0000_0001;
      end
    end
    if (do_stop) begin
      s_d.ctrl[CTRL_RUN] = 1'b0;
    end
    if (access && avs_write) begin
      if (avs_address == ADDR_CTRL) begin
        s_d.ctrl = merge(s_q.ctrl, avs_writedata, wmask) & 32'h0000_007F;
        if (do_stop) begin
          s_d.ctrl[CTRL_RUN] = 1'b0;
        end
      end else if (avs_address == ADDR_PRESCALE) begin
        s_d.prescale = merge(s_q.prescale, avs_writedata, wmask);
      end else if (avs_address == ADDR_MATCH_CTRL) begin
        s_d.match_ctrl = 21'(merge(32'(s_q.match_ctrl), avs_writedata, wmask));
      end else if (avs_address == ADDR_EDGE_MODE) begin
        s_d.edge_mode = 6'(merge(32'(s_q.edge_mode), avs_writedata, wmask));
      end else if (avs_address == ADDR_OUT_ENABLE) begin
        s_d.out_en = 6'(merge(32'(s_q.out_en), avs_writedata, wmask));
      end else if (avs_address == ADDR_IRQ_STATUS) begin
        clr_bits = 7'(avs_writedata & wmask);
      end else if (avs_address == ADDR_IRQ_MASK) begin
        s_d.irq_mask = 7'(merge(32'(s_q.irq_mask), avs_writedata, wmask));
      end else if (avs_address >= ADDR_MATCH_BASE && avs_address[4:2] != 3'h7) begin
        s_d.match[avs_address[4:2]] =
          merge(s_q.match[avs_address[4:2]], avs_writedata, wmask);
      end
    end
    // Sticky status: a new event wins over a write-one clear.
    for (int i = 0; i < NUM_MATCH; i++) begin
      s_d.irq_status[i] = (s_q.irq_status[i] & ~clr_bits[i]) |
                          (hit[i] & s_q.match_ctrl[3*i+MC_IRQ]);
    end
    s_d.rdata = s_q.rdata;
    if (access && avs_read) begin
      if (avs_address == ADDR_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (avs_address == ADDR_COUNT) begin
        s_d.rdata = s_q.count;
      end else if (avs_address == ADDR_PRESCALE) begin
        s_d.rdata = s_q.prescale;
      end else if (avs_address == ADDR_MATCH_CTRL) begin
        s_d.rdata = 32'(s_q.match_ctrl);
      end else if (avs_address == ADDR_EDGE_MODE) begin
        s_d.rdata = 32'(s_q.edge_mode);
      end else if (avs_address == ADDR_OUT_ENABLE) begin
        s_d.rdata = 32'(s_q.out_en);
      end else if (avs_address == ADDR_IRQ_STATUS) begin
        s_d.rdata = 32'(s_q.irq_status);
      end else if (avs_address == ADDR_IRQ_MASK) begin
        s_d.rdata = 32'(s_q.irq_mask);
      end else if (avs_address >= ADDR_MATCH_BASE && avs_address[4:2] != 3'h7) begin
        s_d.rdata = s_q.match[avs_address[4:2]];
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign irq = |(s_q.irq_status & s_q.irq_mask);
endmodule

// [pwm_load.sv]
// Load model that totals the cycles each PWM output spends high.
`timescale 1ns/100ps
module pwm_load
  import pwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [NUM_OUT-1:0] pwm_out,
  output logic [7:0] hi_cnt [NUM_OUT]
);
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_OUT; i++) begin
      hi_cnt[i] <= clr ? 8'h00 : hi_cnt[i] + 8'(pwm_out[i]);
    end
  end
endmodule

// [match_based_pwm_unit_assertions.sv]
// Checker for the bus, interrupt and outputs of the match PWM unit.
`timescale 1ns/100ps
module pwm_unit_checker
  import pwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [CAP_W-1:0] capture_in,
  input wire logic [NUM_OUT-1:0] pwm_out,
  input wire logic irq
);
  logic [31:0] oe_q;
  logic [31:0] mask_q;
  logic run_q;
  logic take;
  // Shadows follow full-word writes at the edge where the slave takes them.
  assign take = avs_write && avs_waitrequest && avs_byteenable == 4'hF;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oe_q <= '0;
      mask_q <= '0;
      run_q <= 1'b0;
    end else if (take) begin
      if (avs_address == ADDR_OUT_ENABLE) oe_q <= avs_writedata;
      if (avs_address == ADDR_IRQ_MASK) mask_q <= avs_writedata;
      if (avs_address == ADDR_CTRL) run_q <= avs_writedata[CTRL_RUN];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_done; (avs_read || avs_write) && !avs_waitrequest; endsequence
  property p_one_wait; s_req |=> s_done; endproperty
  property p_first_wait; $rose(avs_read) |-> avs_waitrequest; endproperty
  property p_unmapped; s_done and avs_read && avs_address == 6'h3C |-> avs_readdata == '0;
  endproperty
  property p_oe_rd; s_done and avs_read && avs_address == ADDR_OUT_ENABLE |-> avs_readdata == oe_q;
  endproperty
  property p_mask_rd; s_done and avs_read && avs_address == ADDR_IRQ_MASK |-> avs_readdata == mask_q;
  endproperty
  property p_irq_off; mask_q == '0 |-> !irq; endproperty
  property p_gate; (pwm_out & ~oe_q[NUM_OUT-1:0]) == '0; endproperty
  property p_hold;
    !(run_q || $past(run_q) || $past(run_q, 2) || $past(run_q, 3)) && $stable(oe_q) |-> $stable(pwm_out);
  endproperty
  a_one_wait: assert property(p_one_wait) else $error("wait not one cycle");
  a_first_wait: assert property(p_first_wait) else $error("no wait cycle");
  a_unmapped: assert property(p_unmapped) else $error("unmapped read not zero");
  a_oe_rd: assert property(p_oe_rd) else $error("enable readback wrong");
  a_mask_rd: assert property(p_mask_rd) else $error("mask readback wrong");
  a_irq_off: assert property(p_irq_off) else $error("irq while masked");
  a_gate: assert property(p_gate) else $error("disabled output high");
  a_hold: assert property(p_hold) else $error("output moved while stopped");
endmodule
bind match_based_pwm_unit pwm_unit_checker i_pwm_unit_checker(
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .capture_in(capture_in), .pwm_out(pwm_out), .irq(irq));

// [match_based_pwm_unit_test.sv]
// Self-checking bench for the match PWM unit.
`timescale 1ns/100ps
module match_based_pwm_unit_test;
  import pwm_pkg::*;
  typedef struct {logic [5:0] a; logic [31:0] w; logic [31:0] r;} row_t;
  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, irq, clr;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, r2;
  logic [3:0] avs_byteenable;
  logic [CAP_W-1:0] capture_in;
  logic [NUM_OUT-1:0] pwm_out;
  logic [7:0] hi_cnt [NUM_OUT];
  int miscompares, checks, cyc, e;
  int m [7] = '{9, 3, 6, 1, 8, 2, 5};
  row_t rows [11];
  match_based_pwm_unit i_match_based_pwm_unit(.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capture_in(capture_in), .pwm_out(pwm_out), .irq(irq));
  pwm_load i_pwm_load(.clk_sys(clk_sys), .clr(clr), .pwm_out(pwm_out), .hi_cnt(hi_cnt));
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  // The request is held until an edge sees waitrequest low; data is taken there.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk_sys);
  endtask
  task automatic window;
    clr <= 1;
    @(posedge clk_sys);
    clr <= 0;
    // One edge more than a period, since the total of the current edge lands after this step.
    repeat (11) @(posedge clk_sys);
  endtask
  initial begin
    {rst, avs_read, avs_write, clr} = 4'h9;
    {avs_address, avs_writedata, capture_in} = '0;
    avs_byteenable = 4'hF;
    for (int i = 0; i < 7; i++) rows[i] = '{6'(ADDR_MATCH_BASE + 6'(4 * i)), m[i], m[i]};
    rows[7] = '{ADDR_OUT_ENABLE, 32'h3F, 32'h3F};
    rows[8] = '{6'h3C, 32'h5, 32'h0};
    rows[9] = '{ADDR_COUNT, 32'h7, 32'h0};
    rows[10] = '{ADDR_IRQ_MASK, 32'h10, 32'h10};
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    chk("pwm_out", 32'(pwm_out), 32'h0);
    chk("irq", 32'(irq), 32'h0);
    foreach (rows[i]) begin
      bus(1, rows[i].a, rows[i].w);
      bus(0, rows[i].a, 0);
      chk("register", rd, rows[i].r);
    end
    bus(1, ADDR_EDGE_MODE, 32'h6);
    bus(1, ADDR_CTRL, 32'h1);
    repeat (25) @(posedge clk_sys);
    window();
    for (int n = 1; n <= 6; n++) begin
      e = (n == 2 || n == 3) ? (m[n] - m[n-1] + 10) % 10 : m[n] + 1;
      chk("duty", 32'(hi_cnt[n-1]), 32'(e));
    end
    bus(1, ADDR_MATCH_CTRL, 32'h5000);
    repeat (12) @(posedge clk_sys);
    chk("irq", 32'(irq), 32'h1);
    bus(0, ADDR_CTRL, 0);
    chk("run", 32'(rd[CTRL_RUN]), 32'h0);
    bus(0, ADDR_COUNT, 0);
    r2 = rd;
    bus(0, ADDR_COUNT, 0);
    chk("count", rd, r2);
    bus(0, ADDR_IRQ_STATUS, 0);
    chk("status", 32'(rd[4]), 32'h1);
    bus(1, ADDR_IRQ_MASK, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    bus(1, ADDR_IRQ_MASK, 32'h10);
    bus(1, ADDR_IRQ_STATUS, 32'h10);
    chk("irq", 32'(irq), 32'h0);
    bus(1, ADDR_MATCH_CTRL, 32'h10);
    bus(1, ADDR_CTRL, 32'h1);
    repeat (3) begin
      repeat (7) @(posedge clk_sys);
      bus(0, ADDR_COUNT, 0);
      chk("wrap", 32'(rd <= 32'h3), 32'h1);
    end
    bus(1, ADDR_CTRL, 32'h2);
    bus(1, ADDR_CTRL, 32'h5);
    repeat (3) begin
      capture_in <= 4'h3;
      repeat (3) @(posedge clk_sys);
      capture_in <= 4'h0;
      repeat (3) @(posedge clk_sys);
    end
    bus(0, ADDR_COUNT, 0);
    chk("edges", rd, 32'h3);
    bus(1, ADDR_CTRL, 32'h2);
    bus(1, ADDR_CTRL, 32'h4D);
    repeat (3) begin
      capture_in <= 4'h2;
      repeat (3) @(posedge clk_sys);
      capture_in <= 4'h0;
      repeat (3) @(posedge clk_sys);
    end
    bus(0, ADDR_COUNT, 0);
    chk("both_edges", rd, 32'h2);
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    chk("pwm_out", 32'(pwm_out), 32'h0);
    chk("irq", 32'(irq), 32'h0);
    bus(0, ADDR_COUNT, 0);
    chk("count", rd, 32'h0);
    end_sim();
  end
endmodule
